// *** core/nvm_access.sv ***
// Flash and EEPROM access: AHB-Lite slave, page buffers and erase/program.
// Assumes an AHB-Lite master on the system clock and operation strobes as pulses.
`timescale 1ns/100ps
`default_nettype none
module nvm_access #(
  parameter int ERASE_CYCLES = nvm_pkg::FL_ERASE_CYCLES,
  parameter int PROG_CYCLES  = nvm_pkg::FL_PROG_CYCLES,
  parameter int EE_CYCLES    = nvm_pkg::EE_PROG_CYCLES
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic        i_flash_erase,
  input  wire logic        i_flash_program,
  input  wire logic        i_ee_program,
  input  wire logic [4:0]  i_sector_sel,
  input  wire logic        i_sector_protect,
  input  wire logic        i_sector_unprotect,
  input  wire logic        i_sector_lock,
  output logic             o_busy,
  output logic [31:0]      o_sector_protected,
  output logic [31:0]      o_sector_locked
);
  localparam int FL_IDX_W = $clog2(nvm_pkg::FL_WORDS);
  localparam int EE_IDX_W = $clog2(nvm_pkg::EE_HALFWORDS);

  typedef enum logic [1:0] {RESP_OKAY, RESP_ERR1, RESP_ERR2} resp_t;

  // Arrays sized from the geometry; no reset, contents are nonvolatile
  logic [31:0] flash_mem [nvm_pkg::FL_WORDS];
  logic [15:0] ee_mem    [nvm_pkg::EE_HALFWORDS];
  logic [31:0] fl_buf    [nvm_pkg::FL_WORDS_PER_ROW];
  logic [15:0] ee_buf    [nvm_pkg::EE_HW_PER_ROW];

  logic [31:0] ee_mask_reg;
  logic [9:0]  fl_row_reg;
  logic [5:0]  ee_row_reg;
  logic        wr_pend_reg;
  logic        wr_ee_reg;
  logic        wr_half_reg;
  logic [14:0] wr_addr_reg;
  logic [31:0] prot_reg;
  logic [31:0] lock_reg;
  logic        busy_reg;
  logic        hready_reg;
  logic        hresp_reg;
  logic [31:0] hrdata_reg;
  resp_t       resp_reg;
  resp_t       resp_next;

  nvm_timer_if tif ();

  nvm_op_timer u_timer (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .tif       (tif)
  );

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] base,
                                    input int bits);
    in_range = ((a ^ base) >> bits) == 32'h0;
  endfunction

  // Address phase decode
  wire        take    = i_hsel && i_hready && i_htrans[1];
  wire        hit_fl  = in_range(i_haddr, nvm_pkg::FL_BASE, nvm_pkg::FL_ADDR_BITS);
  wire        hit_ee  = in_range(i_haddr, nvm_pkg::EE_BASE, nvm_pkg::EE_ADDR_BITS);
  // Flash writes take whole words only; EEPROM writes take halfwords or words
  wire        size_ok = hit_fl ? (i_hsize == nvm_pkg::HSIZE_WORD)
                               : (i_hsize == nvm_pkg::HSIZE_WORD ||
                                  i_hsize == nvm_pkg::HSIZE_HALF);
  wire        bad     = take && (!(hit_fl || hit_ee) || (i_hwrite && !size_ok));
  wire        wr_take = take && i_hwrite && !bad;
  wire [FL_IDX_W-1:0] fl_rd_idx = i_haddr[FL_IDX_W+1:2];
  wire [EE_IDX_W-1:0] ee_rd_lo  = {i_haddr[EE_IDX_W:2], 1'b0};
  wire [EE_IDX_W-1:0] ee_rd_hi  = {i_haddr[EE_IDX_W:2], 1'b1};
  wire [31:0] fl_rd   = flash_mem[fl_rd_idx];
  wire [31:0] ee_rd   = {ee_mem[ee_rd_hi], ee_mem[ee_rd_lo]};
  wire [31:0] rd_sel  = hit_fl ? fl_rd : ee_rd;

  // Data phase write decode
  wire [3:0]  wr_fl_word = wr_addr_reg[5:2];
  wire [4:0]  wr_ee_hw   = wr_addr_reg[5:1];
  wire        wr_usable  = wr_addr_reg[14:10] < 5'(nvm_pkg::FL_USABLE_SECT);

  // Operation qualification
  wire [4:0]  op_sector  = fl_row_reg[8:4];
  wire [3:0]  op_row     = fl_row_reg[3:0];
  wire        sect_free  = !prot_reg[op_sector] && !lock_reg[op_sector]
                           && op_sector < 5'(nvm_pkg::FL_USABLE_SECT);
  wire        ee_free    = ee_row_reg < 6'(nvm_pkg::EE_ROWS - nvm_pkg::EE_LOCKED_ROWS);
  wire        any_req    = i_flash_erase || i_flash_program || i_ee_program;
  wire        op_start   = any_req && !busy_reg;
  wire        do_erase   = op_start && i_flash_erase;
  wire        do_prog    = op_start && !i_flash_erase && i_flash_program;
  wire        do_ee      = op_start && !i_flash_erase && !i_flash_program;
  wire [31:0] op_cycles  = do_erase ? ERASE_CYCLES : do_prog ? PROG_CYCLES : EE_CYCLES;

  assign tif.start  = op_start;
  assign tif.cycles = op_cycles[nvm_pkg::CNT_W-1:0];

  always_comb begin
    resp_next = RESP_OKAY;
    case (resp_reg)
      RESP_ERR1: resp_next = RESP_ERR2;
      default:   resp_next = bad ? RESP_ERR1 : RESP_OKAY;
    endcase
  end

  // Bus response and read data
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      resp_reg   <= RESP_OKAY;
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      resp_reg   <= resp_next;
      hready_reg <= resp_next != RESP_ERR1;
      hresp_reg  <= resp_next != RESP_OKAY;
      if (take && !i_hwrite && !bad) begin
        hrdata_reg <= rd_sel;
      end
    end
  end

  // Write address capture
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wr_pend_reg <= 1'b0;
      wr_ee_reg   <= 1'b0;
      wr_half_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= wr_take && resp_reg != RESP_ERR1;
      wr_ee_reg   <= hit_ee;
      wr_half_reg <= i_hsize == nvm_pkg::HSIZE_HALF;
      wr_addr_reg <= i_haddr[14:0];
    end
  end

  // Bus writes land in a page buffer, never in the array
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      fl_row_reg  <= '0;
      ee_row_reg  <= '0;
      ee_mask_reg <= '0;
    end else begin
      if (wr_pend_reg && !wr_ee_reg && wr_usable) begin
        fl_buf[wr_fl_word] <= i_hwdata;
        fl_row_reg         <= {1'b0, wr_addr_reg[14:6]};
      end
      if (wr_pend_reg && wr_ee_reg) begin
        ee_row_reg <= wr_addr_reg[11:6];
        if (wr_half_reg) begin
          ee_buf[wr_ee_hw] <= wr_addr_reg[1] ? i_hwdata[31:16] : i_hwdata[15:0];
        end else begin
          ee_buf[{wr_ee_hw[4:1], 1'b0}] <= i_hwdata[15:0];
          ee_buf[{wr_ee_hw[4:1], 1'b1}] <= i_hwdata[31:16];
        end
      end
      // A buffer write in the commit cycle survives the mask clear
      if (do_ee) begin
        ee_mask_reg <= '0;
      end
      if (wr_pend_reg && wr_ee_reg) begin
        if (wr_half_reg) begin
          ee_mask_reg[wr_ee_hw] <= 1'b1;
        end else begin
          ee_mask_reg[{wr_ee_hw[4:1], 1'b0}] <= 1'b1;
          ee_mask_reg[{wr_ee_hw[4:1], 1'b1}] <= 1'b1;
        end
      end
      if (do_prog) begin
        for (int w = 0; w < nvm_pkg::FL_WORDS_PER_ROW; w++) begin
          fl_buf[w] <= nvm_pkg::FL_ERASED;
        end
      end
    end
  end

  // Array updates happen at operation start; the timer then holds busy.
  // Trade-off: the buffer is free again at once, at the cost of reads
  // seeing new data before the operation time has elapsed.
  always_ff @(posedge i_sys_clk) begin
    if (do_erase && sect_free) begin
      for (int w = 0; w < nvm_pkg::FL_ROWS_PER_SECT * nvm_pkg::FL_WORDS_PER_ROW; w++) begin
        flash_mem[{op_sector, 8'(w)}] <= nvm_pkg::FL_ERASED;
      end
    end
    if (do_prog && sect_free) begin
      for (int w = 0; w < nvm_pkg::FL_WORDS_PER_ROW; w++) begin
        flash_mem[{op_sector, op_row, 4'(w)}] <=
          flash_mem[{op_sector, op_row, 4'(w)}] & fl_buf[w];
      end
    end
    if (do_ee && ee_free) begin
      for (int w = 0; w < nvm_pkg::EE_HW_PER_ROW; w++) begin
        if (ee_mask_reg[w]) begin
          ee_mem[{ee_row_reg, 5'(w)}] <= ee_buf[w];
        end
      end
    end
  end

  // Sector protection and locking
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      prot_reg <= nvm_pkg::PROT_RESET;
      lock_reg <= nvm_pkg::LOCK_RESET;
    end else begin
      if (i_sector_protect) begin
        prot_reg[i_sector_sel] <= 1'b1;
      end else if (i_sector_unprotect) begin
        prot_reg[i_sector_sel] <= 1'b0;
      end
      if (i_sector_lock) begin
        lock_reg[i_sector_sel] <= 1'b1;
      end
    end
  end

  // Busy from start until the timer reports done
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      busy_reg <= 1'b0;
    end else if (op_start) begin
      busy_reg <= 1'b1;
    end else if (tif.done) begin
      busy_reg <= 1'b0;
    end
  end

  assign o_hreadyout        = hready_reg;
  assign o_hresp            = hresp_reg;
  assign o_hrdata           = hrdata_reg;
  assign o_busy             = busy_reg;
  assign o_sector_protected = prot_reg;
  assign o_sector_locked    = lock_reg;
endmodule // nvm_access
`default_nettype wire

// *** core/nvm_op_timer.sv ***
// Times one erase or program operation.
// Assumes start is a single-cycle pulse given only while idle.
`timescale 1ns/100ps
`default_nettype none
module nvm_op_timer (
  input  wire logic   i_sys_clk,
  input  wire logic   i_reset,
  nvm_timer_if.timer  tif
);
  logic [nvm_pkg::CNT_W-1:0] cnt_reg;
  logic [nvm_pkg::CNT_W-1:0] cnt_next;
  logic                      busy_reg;
  logic                      done_reg;
  wire                       last = busy_reg && (cnt_reg == '0);

  assign cnt_next = tif.start ? tif.cycles - 1'b1 : cnt_reg - 1'b1;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= last;
      if (tif.start && !busy_reg) begin
        cnt_reg  <= cnt_next;
        busy_reg <= 1'b1;
      end else if (last) begin
        busy_reg <= 1'b0;
      end else if (busy_reg) begin
        cnt_reg  <= cnt_next;
      end
    end
  end

  assign tif.busy = busy_reg;
  assign tif.done = done_reg;
endmodule // nvm_op_timer
`default_nettype wire

// *** inc/nvm_pkg.sv ***
// Constants shared by the flash and EEPROM access logic.
// Assumes a single 250 MHz system clock.
package nvm_pkg;
  localparam int          CLK_PERIOD_NS    = 4;
  // Flash geometry
  localparam int          FL_SECTORS       = 32;
  localparam int          FL_USABLE_SECT   = 30;
  localparam int          FL_ROWS_PER_SECT = 16;
  localparam int          FL_WORDS_PER_ROW = 16;
  localparam int          FL_WORDS         = FL_SECTORS * FL_ROWS_PER_SECT * FL_WORDS_PER_ROW;
  localparam logic [31:0] FL_ERASED        = 32'hffff_ffff;
  // EEPROM geometry
  localparam int          EE_ROWS          = 64;
  localparam int          EE_LOCKED_ROWS   = 4;
  localparam int          EE_HW_PER_ROW    = 32;
  localparam int          EE_HALFWORDS     = EE_ROWS * EE_HW_PER_ROW;
  // Address map, byte addresses
  localparam logic [31:0] FL_BASE          = 32'h0000_0000;
  localparam int          FL_ADDR_BITS     = 15;
  localparam logic [31:0] EE_BASE          = 32'h0001_0000;
  localparam int          EE_ADDR_BITS     = 12;
  // Protection reset value: all sectors guarded
  localparam logic [31:0] PROT_RESET       = 32'hffff_ffff;
  localparam logic [31:0] LOCK_RESET       = 32'h0000_0000;
  // Operation times and derived cycle counts
  localparam int          FL_ERASE_NS      = 2000;
  localparam int          FL_PROG_NS       = 1000;
  localparam int          EE_PROG_NS       = 4000;
  localparam int          FL_ERASE_CYCLES  = (FL_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FL_PROG_CYCLES   = (FL_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          EE_PROG_CYCLES   = (EE_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W            = 16;
  // AHB encodings
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_HALF       = 3'h1;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
endpackage

// *** inc/nvm_timer_if.sv ***
// Handshake between the access logic and its operation timer.
// Assumes both ends share the system clock.
`timescale 1ns/100ps
`default_nettype none
interface nvm_timer_if;
  logic                         start;
  logic [nvm_pkg::CNT_W-1:0]    cycles;
  logic                         busy;
  logic                         done;
  modport ctrl  (output start, output cycles, input busy, input done);
  modport timer (input start, input cycles, output busy, output done);
endinterface
`default_nettype wire

// *** verif/ahb_master_model.sv ***
// AHB-Lite master standing in for the processor core.
// Assumes one transfer at a time, started just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module ahb_master_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_hready,
  input  wire logic        i_hresp,
  input  wire logic [31:0] i_hrdata,
  output logic             o_hsel,
  output logic [31:0]      o_haddr,
  output logic [1:0]       o_htrans,
  output logic             o_hwrite,
  output logic [2:0]       o_hsize,
  output logic [31:0]      o_hwdata
);
  initial begin
    {o_hsel, o_htrans, o_hwrite} = 4'h0;
    {o_haddr, o_hwdata} = 64'h0;
    o_hsize = nvm_pkg::HSIZE_WORD;
  end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
                      input logic [31:0] d, output logic [31:0] rd, output logic er);
    {o_hsel, o_htrans} = {1'b1, nvm_pkg::HTRANS_NONSEQ};
    o_hwrite = w;
    o_hsize = sz;
    o_haddr = a;
    do @(posedge i_sys_clk); while (i_hready !== 1'b1);
    #1;
    // Released address shows its inverse so stale values cannot match
    {o_hsel, o_htrans} = 3'h0;
    o_haddr = ~a;
    o_hwdata = w ? d : ~d;
    do @(posedge i_sys_clk); while (i_hready !== 1'b1);
    rd = i_hrdata;
    er = i_hresp;
    #1;
    o_hwdata = ~d;
  endtask
endmodule // ahb_master_model
`default_nettype wire

// *** verif/nvm_access_asserts.sv ***
// Concurrent checks on the flash and EEPROM access ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module nvm_access_asserts #(
  parameter int ERASE_CYCLES = 4,
  parameter int PROG_CYCLES  = 4,
  parameter int EE_CYCLES    = 4
) (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [2:0]  i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic [31:0] o_hrdata,
  input wire logic        i_flash_erase,
  input wire logic        i_flash_program,
  input wire logic        i_ee_program,
  input wire logic [4:0]  i_sector_sel,
  input wire logic        i_sector_protect,
  input wire logic        i_sector_unprotect,
  input wire logic        i_sector_lock,
  input wire logic        o_busy,
  input wire logic [31:0] o_sector_protected,
  input wire logic [31:0] o_sector_locked
);
  // Loose bound: the busy time is exactly N+1 cycles
  localparam int BUSY_MAX = ERASE_CYCLES + PROG_CYCLES + EE_CYCLES + 8;
  logic take;
  int   busy_cnt;
  assign take = i_hsel & i_hready & i_htrans[1];
  // Counter, since full-size busy times exceed any delay range
  always_ff @(posedge i_sys_clk) begin
    busy_cnt <= (i_reset || !o_busy) ? 0 : busy_cnt + 1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  a_busy_start: assert property (
    (i_flash_erase || i_flash_program || i_ee_program) && !o_busy |=> o_busy)
    else $error("Busy missing after strobe");
  a_busy_hold: assert property (
    $rose(o_busy) |-> o_busy[*3])
    else $error("Busy length wrong");
  a_busy_bound: assert property (
    o_busy |-> busy_cnt <= BUSY_MAX)
    else $error("Busy held too long");
  a_reset_guard: assert property (
    $past(i_reset) |-> o_sector_protected == 32'hffff_ffff && o_sector_locked == 32'h0)
    else $error("Sector state wrong after reset");
  a_lock_sticky: assert property (
    !$past(i_reset) |-> ($past(o_sector_locked) & ~o_sector_locked) == 32'h0)
    else $error("Lock bit cleared");
  a_lock_set: assert property (
    i_sector_lock |=> o_sector_locked[$past(i_sector_sel)])
    else $error("Lock bit not set");
  a_protect_set: assert property (
    i_sector_protect |=> o_sector_protected[$past(i_sector_sel)])
    else $error("Protect bit not set");
  a_read_ok: assert property (
    take && !i_hwrite && i_haddr < 32'h0000_8000 |=> o_hreadyout && !o_hresp)
    else $error("Flash read not zero wait");
  a_unmapped_err: assert property (
    take && i_haddr >= 32'h0001_1000 |=> !o_hreadyout && o_hresp ##1 o_hreadyout && o_hresp)
    else $error("Unmapped access without error");
endmodule // nvm_access_asserts
bind nvm_access nvm_access_asserts #(
  .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES), .EE_CYCLES(EE_CYCLES)
) chk_u (.i_sys_clk, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
  .i_hwdata, .i_hready, .o_hreadyout, .o_hresp, .o_hrdata, .i_flash_erase, .i_flash_program,
  .i_ee_program, .i_sector_sel, .i_sector_protect, .i_sector_unprotect, .i_sector_lock,
  .o_busy, .o_sector_protected, .o_sector_locked);
`default_nettype wire

// *** verif/tb_nvm_access.sv ***
// Self-checking bench for the flash and EEPROM access block.
// Assumes the master model drives AHB; strobes are driven here.
`timescale 1ns/100ps
`default_nettype none
module tb_nvm_access;
  logic        i_sys_clk, i_reset, i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp, o_busy;
  logic [1:0]  i_htrans;
  logic [2:0]  i_hsize;
  logic [31:0] i_haddr, i_hwdata, o_hrdata, o_sector_protected, o_sector_locked, rd;
  logic        i_flash_erase, i_flash_program, i_ee_program, i_sector_protect, er;
  logic        i_sector_unprotect, i_sector_lock;
  logic [4:0]  i_sector_sel;
  int          fails, checks_done, cyc, n;
  assign i_hready = o_hreadyout;
  nvm_access #(.ERASE_CYCLES(4), .PROG_CYCLES(4), .EE_CYCLES(4)) dut_u (.i_sys_clk, .i_reset,
    .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hreadyout,
    .o_hresp, .o_hrdata, .i_flash_erase, .i_flash_program, .i_ee_program, .i_sector_sel,
    .i_sector_protect, .i_sector_unprotect, .i_sector_lock, .o_busy, .o_sector_protected,
    .o_sector_locked);
  ahb_master_model m_u (.i_sys_clk, .i_hready(o_hreadyout), .i_hresp(o_hresp),
    .i_hrdata(o_hrdata), .o_hsel(i_hsel), .o_haddr(i_haddr), .o_htrans(i_htrans),
    .o_hwrite(i_hwrite), .o_hsize(i_hsize), .o_hwdata(i_hwdata));
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rw(input logic w, input logic [31:0] a, input logic [2:0] sz,
                    input logic [31:0] d);
    m_u.xfer(w, a, sz, d, rd, er);
  endtask
  // Strobe again in the fourth busy cycle: a restart would stretch busy
  task automatic op(input int k);
    {i_flash_erase, i_flash_program, i_ee_program} = 3'h4 >> k;
    tick(1);
    for (n = 0; o_busy === 1'b1 && n < 40; n++) begin
      {i_flash_erase, i_flash_program, i_ee_program} = (n == 3) ? (3'h4 >> k) : 3'h0;
      tick(1);
    end
    {i_flash_erase, i_flash_program, i_ee_program} = 3'h0;
    chk("busy cycles", 32'h1, {31'h0, n >= 4 && n <= 7});
    tick(1);
  endtask
  task automatic sect(input logic [4:0] s, input logic [2:0] p);
    i_sector_sel = s;
    {i_sector_protect, i_sector_unprotect, i_sector_lock} = p;
    tick(1);
    {i_sector_protect, i_sector_unprotect, i_sector_lock} = 3'h0;
    tick(1);
  endtask
  task automatic t_flash;
    chk("protected", 32'hffff_ffff, o_sector_protected);
    chk("locked", 32'h0, o_sector_locked);
    sect(5'h0, 3'h2);
    for (int i = 0; i < 16; i++) begin
      rw(1'b1, 32'(i * 4), nvm_pkg::HSIZE_WORD, 32'h5a00_0000 | 32'(i));
    end
    op(0);
    rw(1'b0, 32'h0, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("erased word", nvm_pkg::FL_ERASED, rd);
    op(1);
    for (int i = 0; i < 16; i++) begin
      rw(1'b0, 32'(i * 4), nvm_pkg::HSIZE_WORD, 32'h0);
      chk("flash word", 32'h5a00_0000 | 32'(i), rd);
    end
  endtask
  task automatic t_guard;
    sect(5'h0, 3'h4);
    rw(1'b1, 32'h0, nvm_pkg::HSIZE_WORD, 32'h0);
    op(0);
    op(1);
    rw(1'b0, 32'h0, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("protected word", 32'h5a00_0000, rd);
    sect(5'h0, 3'h3);
    chk("lock bits", 32'h1, o_sector_locked);
    chk("protect bits", 32'hffff_fffe, o_sector_protected);
    op(0);
    rw(1'b0, 32'h0, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("locked word", 32'h5a00_0000, rd);
  endtask
  task automatic t_eeprom;
    for (int i = 0; i < 16; i++) begin
      rw(1'b1, nvm_pkg::EE_BASE + 32'(i * 4), nvm_pkg::HSIZE_WORD, 32'hc0de_0000 | 32'(i));
    end
    op(2);
    rw(1'b1, nvm_pkg::EE_BASE + 32'h6, nvm_pkg::HSIZE_HALF, 32'h7777_0000);
    op(2);
    rw(1'b0, nvm_pkg::EE_BASE + 32'h4, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("ee half lane", 32'h7777_0001, rd);
    rw(1'b0, nvm_pkg::EE_BASE + 32'h8, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("ee kept word", 32'hc0de_0002, rd);
    rw(1'b1, nvm_pkg::EE_BASE + 32'h0f00, nvm_pkg::HSIZE_WORD, 32'h1234_5678);
    op(2);
    rw(1'b0, nvm_pkg::EE_BASE + 32'h0f00, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("ee locked row", 32'h1, {31'h0, rd !== 32'h1234_5678});
  endtask
  task automatic t_err;
    rw(1'b0, 32'h0000_8000, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("hresp past flash", 32'h1, {31'h0, er});
    rw(1'b1, 32'h0, nvm_pkg::HSIZE_HALF, 32'h0);
    chk("hresp flash half", 32'h1, {31'h0, er});
    rw(1'b0, nvm_pkg::EE_BASE + 32'h1000, nvm_pkg::HSIZE_WORD, 32'h0);
    chk("hresp past ee", 32'h1, {31'h0, er});
  endtask
  task automatic finish_test;
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    {i_reset, fails, checks_done, cyc} = {1'b1, 96'h0};
    {i_flash_erase, i_flash_program, i_ee_program, i_sector_sel} = 8'h0;
    {i_sector_protect, i_sector_unprotect, i_sector_lock} = 3'h0;
    tick(3);
    i_reset = 1'b0;
    tick(1);
    t_flash();
    t_guard();
    t_eeprom();
    t_err();
    finish_test();
  end
endmodule // tb_nvm_access
`default_nettype wire
